// [hdl/sar_adc_seq.sv]
// Operation
// - External source: each rising edge of the convert-start pin starts.
// - Writing one to busy starts; busy stays high until conversion ends.
// - Busy falling after the last accumulated conversion sets the done flag; interrupt raised when enabled.
// - Result holds valid data whenever done reads one.
// - Timers 2/3 use low overflow in 8-bit, high in 16-bit mode.
// - Normal tracking: track continuously except during a conversion.
// - Low-power tracking adds three SAR clocks after each start.
// - Low-power with pin source: track while pin low, convert on rise.
// - Burst: wake, convert and accumulate repeat count, then sleep.
// - In burst, power enable sets idle power between bursts.
// - Burst start while powered down waits power-up time first.
// - Burst: one start runs repeat count; otherwise one start each.
// - Done flag set only after repeat count conversions accumulated.
// - Window compare only after repeat count conversions accumulated.
// - Burst tracking uses track time plus three clocks if low-power.
// - Gain select chooses full scale of reference or twice it.
// - 8-bit mode: two fewer clocks, LSBs zero, low byte zero when repeat count is one.
// - 12-bit: four 10-bit conversions with four references combined.
// - 12-bit: largest DAC elements rearranged per sub-conversion.
// - 12-bit result is sum of four 10-bit results, max 4092.
// - 12-bit repeat count is four or more; a setting of one runs four.
// - SAR clock divided from system clock or burst oscillator.
// - Start-mode field selects busy, timer 0/2/3 or pin edge.
// - Accumulated sum right-justified, updated after last conversion.
//
// Design decisions made here: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
module sar_adc_seq #(
   parameter int ADDR_W = 8
) (
   input  wire logic                aclk,
   input  wire logic                aresetn,
   input  wire logic [ADDR_W-1:0]   awaddr,
   input  wire logic                awvalid,
   output wire logic                awready,
   input  wire logic [31:0]         wdata,
   input  wire logic [3:0]          wstrb,
   input  wire logic                wvalid,
   output wire logic                wready,
   output wire logic [1:0]          bresp,
   output wire logic                bvalid,
   input  wire logic                bready,
   input  wire logic [ADDR_W-1:0]   araddr,
   input  wire logic                arvalid,
   output wire logic                arready,
   output wire logic [31:0]         rdata,
   output wire logic [1:0]          rresp,
   output wire logic                rvalid,
   input  wire logic                rready,
   input  wire sar_pkg::sar_timer_s timers,
   input  wire logic                ext_convert_start_pin,
   input  wire logic                lpo_tick,
   input  wire logic                cmp_above,
   output wire logic [9:0]          dac_code,
   output wire sar_pkg::sar_analog_s analog,
   output wire logic                conv_irq
);
   if (ADDR_W < 6) begin : g_chk
      $error("ADDR_W must be at least 6");
   end

   logic                 awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
   logic                 aw_full_q, w_full_q;
   logic [1:0]           bresp_q, rresp_q;
   logic [ADDR_W-1:0]    aw_addr_q;
   logic [31:0]          w_data_q, rdata_q;
   logic [3:0]           w_strb_q;
   logic                 power_en_q, burst_q, lptrk_q, irqen_q;
   logic [2:0]           src_q;
   logic [4:0]           div_q, pwr_q;
   logic                 eight_q, gain_q, twelve_q;
   logic [2:0]           rpt_q, jst_q;
   logic [3:0]           trk_q;
   logic [15:0]          gt_q, lt_q, result_q, accum_q;
   logic                 busy_q, done_q, win_q, irq_q, ext_q, tick_q;
   logic [4:0]           divc_q;
   sar_pkg::sar_state_e  state_q;
   logic [5:0]           tmr_q;
   logic [3:0]           bit_q;
   logic [9:0]           sar_q;
   logic [6:0]           cnt_q;
   sar_pkg::sar_analog_s ana_q;
   logic [31:0]          reg_v [8];
   logic [31:0]          wm;
   logic [2:0]           widx, ridx;
   logic                 whit, rhit, wr_go, wr_ctrl;
   logic                 start_raw, start_ok, fin_conv, last, eight_eff;
   logic                 win_hit;
   logic [6:0]           nconv;
   logic [3:0]           nbits, low_bit;
   logic [5:0]           trk_len;
   logic [15:0]          sum_now, res_fmt;
   sar_pkg::sar_state_e  wait_st;

   assign awready  = awready_q;
   assign wready   = wready_q;
   assign bvalid   = bvalid_q;
   assign bresp    = bresp_q;
   assign arready  = arready_q;
   assign rvalid   = rvalid_q;
   assign rdata    = rdata_q;
   assign rresp    = rresp_q;
   assign dac_code = sar_q;
   assign analog   = ana_q;
   assign conv_irq = irq_q;

   function automatic logic [31:0] merge(input logic [31:0] o,
                                         input logic [31:0] n,
                                         input logic [3:0]  s);
      logic [31:0] r;
      r = o;
      for (int i = 0; i < 4; i++) begin
         if (s[i]) begin
            r[8*i +: 8] = n[8*i +: 8];
         end
      end
      return r;
   endfunction

   function automatic logic [6:0] rpt_count(input logic [2:0] f,
                                            input logic       tw);
      logic [6:0] n;
      n = 7'h40;
      case (f)
         3'h0:    n = tw ? 7'h04 : 7'h01;
         3'h1:    n = 7'h04;
         3'h2:    n = 7'h08;
         3'h3:    n = 7'h10;
         3'h4:    n = 7'h20;
         default: n = 7'h40;
      endcase
      return n;
   endfunction

   always_comb begin
      for (int i = 0; i < 8; i++) begin
         reg_v[i] = 32'h0000_0000;
      end
      reg_v[sar_pkg::OFS_CTRL[4:2]]   = {22'h00_0000, win_q, irqen_q,
         src_q, lptrk_q, busy_q, done_q, burst_q, power_en_q};
      reg_v[sar_pkg::OFS_CFG[4:2]]    = {25'h000_0000, gain_q, eight_q,
                                          div_q};
      reg_v[sar_pkg::OFS_ACC[4:2]]    = {24'h00_0000, twelve_q, 1'b0,
                                          jst_q, rpt_q};
      reg_v[sar_pkg::OFS_TIME[4:2]]   = {20'h0_0000, trk_q, 3'h0, pwr_q};
      reg_v[sar_pkg::OFS_RESULT[4:2]] = {16'h0000, result_q};
      reg_v[sar_pkg::OFS_WIN_GT[4:2]] = {16'h0000, gt_q};
      reg_v[sar_pkg::OFS_WIN_LT[4:2]] = {16'h0000, lt_q};
   end

   assign widx    = aw_addr_q[4:2];
   assign ridx    = araddr[4:2];
   assign whit    = (aw_addr_q[ADDR_W-1:5] == '0) && (widx < sar_pkg::NREG);
   assign rhit    = (araddr[ADDR_W-1:5] == '0) && (ridx < sar_pkg::NREG);
   assign wr_go   = aw_full_q && w_full_q && !bvalid_q;
   assign wm      = merge(reg_v[widx], w_data_q, w_strb_q);
   assign wr_ctrl = wr_go && whit && (widx == sar_pkg::OFS_CTRL[4:2]);

   // Address and data are held separately, so either may arrive first.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready_q <= 1'b1;
         wready_q  <= 1'b1;
         aw_full_q <= 1'b0;
         w_full_q  <= 1'b0;
         bvalid_q  <= 1'b0;
         bresp_q   <= sar_pkg::RESP_OKAY;
         aw_addr_q <= '0;
         w_data_q  <= 32'h0000_0000;
         w_strb_q  <= 4'h0;
      end else begin
         if (awvalid && awready_q) begin
            aw_addr_q <= awaddr;
            awready_q <= 1'b0;
            aw_full_q <= 1'b1;
         end
         if (wvalid && wready_q) begin
            w_data_q <= wdata;
            w_strb_q <= wstrb;
            wready_q <= 1'b0;
            w_full_q <= 1'b1;
         end
         if (wr_go) begin
            aw_full_q <= 1'b0;
            w_full_q  <= 1'b0;
            bvalid_q  <= 1'b1;
            bresp_q   <= whit ? sar_pkg::RESP_OKAY : sar_pkg::RESP_SLVERR;
         end
         if (bvalid_q && bready) begin
            bvalid_q  <= 1'b0;
            awready_q <= 1'b1;
            wready_q  <= 1'b1;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_q <= 1'b1;
         rvalid_q  <= 1'b0;
         rdata_q   <= 32'h0000_0000;
         rresp_q   <= sar_pkg::RESP_OKAY;
      end else begin
         if (arvalid && arready_q) begin
            arready_q <= 1'b0;
            rvalid_q  <= 1'b1;
            rdata_q   <= rhit ? reg_v[ridx] : 32'h0000_0000;
            rresp_q   <= rhit ? sar_pkg::RESP_OKAY : sar_pkg::RESP_SLVERR;
         end else if (rvalid_q && rready) begin
            rvalid_q  <= 1'b0;
            arready_q <= 1'b1;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         power_en_q <= 1'b0;
         burst_q    <= 1'b0;
         lptrk_q    <= 1'b0;
         irqen_q    <= 1'b0;
         src_q      <= sar_pkg::SRC_BUSY;
         div_q      <= sar_pkg::RST_DIV;
         eight_q    <= 1'b0;
         gain_q     <= 1'b0;
         twelve_q   <= 1'b0;
         rpt_q      <= 3'h0;
         jst_q      <= 3'h0;
         pwr_q      <= sar_pkg::RST_PWR;
         trk_q      <= sar_pkg::RST_TRK;
         gt_q       <= 16'h0000;
         lt_q       <= 16'h0000;
      end else if (wr_go && whit) begin
         case (widx)
            sar_pkg::OFS_CTRL[4:2]: begin
               power_en_q <= wm[sar_pkg::CTRL_PWR];
               burst_q    <= wm[sar_pkg::CTRL_BURST];
               lptrk_q    <= wm[sar_pkg::CTRL_LPTRK];
               src_q      <= wm[sar_pkg::CTRL_SRC +: 3];
               irqen_q    <= wm[sar_pkg::CTRL_IRQEN];
            end
            sar_pkg::OFS_CFG[4:2]: begin
               div_q   <= wm[sar_pkg::CFG_DIV +: 5];
               eight_q <= wm[sar_pkg::CFG_EIGHT];
               gain_q  <= wm[sar_pkg::CFG_GAIN];
            end
            sar_pkg::OFS_ACC[4:2]: begin
               rpt_q    <= wm[sar_pkg::ACC_RPT +: 3];
               jst_q    <= wm[sar_pkg::ACC_JST +: 3];
               twelve_q <= wm[sar_pkg::ACC_TWELVE];
            end
            sar_pkg::OFS_TIME[4:2]: begin
               pwr_q <= wm[sar_pkg::TIME_PWR +: 5];
               trk_q <= wm[sar_pkg::TIME_TRK +: 4];
            end
            sar_pkg::OFS_WIN_GT[4:2]: gt_q <= wm[15:0];
            sar_pkg::OFS_WIN_LT[4:2]: lt_q <= wm[15:0];
            default: begin
            end
         endcase
      end
   end

   // The burst oscillator arrives as a synchronous tick, so one clock serves.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         divc_q <= 5'h00;
         tick_q <= 1'b0;
      end else begin
         tick_q <= 1'b0;
         if (!burst_q || lpo_tick) begin
            if (divc_q >= div_q) begin
               divc_q <= 5'h00;
               tick_q <= 1'b1;
            end else begin
               divc_q <= divc_q + 5'h01;
            end
         end
      end
   end

   always_comb begin
      case (src_q)
         sar_pkg::SRC_BUSY: start_raw = wr_ctrl && wm[sar_pkg::CTRL_BUSY];
         sar_pkg::SRC_T0:   start_raw = timers.t0_ovf;
         sar_pkg::SRC_T2:   start_raw = timers.t2_16bit ? timers.t2_hi_ovf
            : timers.t2_lo_ovf;
         sar_pkg::SRC_T3:   start_raw = timers.t3_16bit ? timers.t3_hi_ovf
            : timers.t3_lo_ovf;
         sar_pkg::SRC_EXT:  start_raw = ext_convert_start_pin
            && !ext_q;
         default:           start_raw = 1'b0;
      endcase
   end

   // Without burst the converter must already be powered to accept a start.
   assign start_ok  = start_raw && (state_q == sar_pkg::ST_IDLE)
                      && (burst_q || power_en_q);
   assign eight_eff = eight_q && !twelve_q;
   assign nbits     = eight_eff ? sar_pkg::BITS_EIGHT
                                : sar_pkg::BITS_TEN;
   assign low_bit   = sar_pkg::BITS_TEN - nbits;
   assign nconv     = rpt_count(rpt_q, twelve_q);
   assign last      = (cnt_q + 7'h01) >= nconv;
   assign fin_conv  = (state_q == sar_pkg::ST_CONV) && tick_q
                      && (tmr_q == {2'b00, nbits + sar_pkg::CONV_EXTRA
                                    - 4'h1});
   assign sum_now   = accum_q + {6'h00, sar_q};
   assign wait_st   = (trk_len == 6'h00) ? sar_pkg::ST_CONV : sar_pkg::ST_TRACK;

   always_comb begin
      if (burst_q) begin
         trk_len = {2'b00, trk_q}
                   + (lptrk_q ? sar_pkg::LP_TRACK_TICKS : 6'h00);
      end else if (lptrk_q && (src_q != sar_pkg::SRC_EXT)) begin
         trk_len = sar_pkg::LP_TRACK_TICKS;
      end else begin
         trk_len = 6'h00;
      end
   end

   always_comb begin
      if (nconv == 7'h01 && eight_eff) begin
         res_fmt = {sar_q[9:2], 8'h00};
      end else if (nconv == 7'h01 && jst_q[2]) begin
         res_fmt = {sar_q, 6'h00};
      end else begin
         res_fmt = sum_now >> jst_q[1:0];
      end
      if (gt_q < lt_q) begin
         win_hit = (res_fmt > gt_q) && (res_fmt < lt_q);
      end else begin
         win_hit = (res_fmt > gt_q) || (res_fmt < lt_q);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_q <= sar_pkg::ST_IDLE;
         tmr_q   <= 6'h00;
         bit_q   <= sar_pkg::BIT_TOP;
         sar_q   <= sar_pkg::SAR_INIT;
         cnt_q   <= 7'h00;
         accum_q <= 16'h0000;
         busy_q  <= 1'b0;
         ext_q   <= 1'b0;
      end else begin
         ext_q <= ext_convert_start_pin;
         if (state_q != sar_pkg::ST_CONV) begin
            sar_q <= sar_pkg::SAR_INIT;
            bit_q <= sar_pkg::BIT_TOP;
         end
         case (state_q)
            sar_pkg::ST_IDLE: begin
               tmr_q <= 6'h00;
               if (start_ok) begin
                  busy_q  <= 1'b1;
                  state_q <= (burst_q && !power_en_q) ? sar_pkg::ST_PWRUP
                                                      : wait_st;
               end
            end
            sar_pkg::ST_PWRUP: begin
               if (tick_q) begin
                  tmr_q <= tmr_q + 6'h01;
                  if ((tmr_q + 6'h01) >= {1'b0, pwr_q}) begin
                     tmr_q   <= 6'h00;
                     state_q <= wait_st;
                  end
               end
            end
            sar_pkg::ST_TRACK: begin
               if (tick_q) begin
                  tmr_q <= tmr_q + 6'h01;
                  if ((tmr_q + 6'h01) >= trk_len) begin
                     tmr_q   <= 6'h00;
                     state_q <= sar_pkg::ST_CONV;
                  end
               end
            end
            sar_pkg::ST_CONV: begin
               if (tick_q) begin
                  tmr_q <= tmr_q + 6'h01;
                  if (tmr_q < {2'b00, nbits}) begin
                     if (!cmp_above) begin
                        sar_q[bit_q] <= 1'b0;
                     end
                     if (bit_q > low_bit) begin
                        sar_q[bit_q - 4'h1] <= 1'b1;
                     end
                     bit_q <= bit_q - 4'h1;
                  end
               end
               if (fin_conv) begin
                  tmr_q   <= 6'h00;
                  sar_q   <= sar_pkg::SAR_INIT;
                  bit_q   <= sar_pkg::BIT_TOP;
                  accum_q <= last ? 16'h0000 : sum_now;
                  cnt_q   <= last ? 7'h00 : cnt_q + 7'h01;
                  if (burst_q && !last) begin
                     state_q <= wait_st;
                  end else begin
                     state_q <= sar_pkg::ST_IDLE;
                     busy_q  <= 1'b0;
                  end
               end
            end
            default: state_q <= sar_pkg::ST_IDLE;
         endcase
      end
   end

   // Set is written last so a finishing series beats a software clear.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         done_q   <= 1'b0;
         win_q    <= 1'b0;
         result_q <= 16'h0000;
         irq_q    <= 1'b0;
      end else begin
         if (wr_ctrl && !wm[sar_pkg::CTRL_DONE]) begin
            done_q <= 1'b0;
         end
         if (wr_ctrl && !wm[sar_pkg::CTRL_WIN]) begin
            win_q <= 1'b0;
         end
         if (fin_conv && last) begin
            done_q   <= 1'b1;
            result_q <= res_fmt;
            if (win_hit) begin
               win_q <= 1'b1;
            end
         end
         irq_q <= done_q && irqen_q;
      end
   end

   // Tracking in idle keeps the sample cap settled for the next start.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ana_q <= '0;
      end else begin
         ana_q.power_on  <= power_en_q || (burst_q
                            && state_q != sar_pkg::ST_IDLE);
         ana_q.gain_half <= gain_q;
         ana_q.ref_step  <= twelve_q ? cnt_q[1:0] : 2'b00;
         ana_q.dem_sel   <= twelve_q ? cnt_q[1:0] : 2'b00;
         if (state_q == sar_pkg::ST_TRACK) begin
            ana_q.track <= 1'b1;
         end else if (state_q == sar_pkg::ST_IDLE && !burst_q
                      && power_en_q) begin
            ana_q.track <= lptrk_q ? (src_q == sar_pkg::SRC_EXT
                                      && !ext_convert_start_pin)
                                   : 1'b1;
         end else begin
            ana_q.track <= 1'b0;
         end
      end
   end

   a_busy_on_start: assert property (
      @(posedge aclk) disable iff (!aresetn)
      start_ok |=> busy_q) else $error("busy not set by start");
   a_done_on_fall: assert property (
      @(posedge aclk) disable iff (!aresetn)
      $rose(done_q) |-> $fell(busy_q)) else $error("done without fall");
   a_irq_follows: assert property (
      @(posedge aclk) disable iff (!aresetn)
      done_q && irqen_q |=> irq_q) else $error("irq missing");
   a_result_hold: assert property (
      @(posedge aclk) disable iff (!aresetn)
      !$stable(result_q) |-> $rose(done_q)) else $error("result moved");
   a_lp_track: assert property (
      @(posedge aclk) disable iff (!aresetn)
      start_ok && !burst_q && lptrk_q && src_q != sar_pkg::SRC_EXT
      |=> state_q == sar_pkg::ST_TRACK) else $error("no lp track");
   a_eight_low: assert property (
      @(posedge aclk) disable iff (!aresetn)
      fin_conv && last && eight_eff && nconv == 7'h01
      |=> result_q[7:0] == 8'h00) else $error("low byte not zero");
   a_burst_pwrup: assert property (
      @(posedge aclk) disable iff (!aresetn)
      start_ok && burst_q && !power_en_q
      |=> state_q == sar_pkg::ST_PWRUP) else $error("no power-up");
   a_no_restart: assert property (
      @(posedge aclk) disable iff (!aresetn)
      state_q != sar_pkg::ST_IDLE && !tick_q
      |=> $stable(cnt_q) && $stable(tmr_q)) else $error("restarted");
   a_ext_edge: assert property (
      @(posedge aclk) disable iff (!aresetn)
      src_q == sar_pkg::SRC_EXT && ext_convert_start_pin && !ext_q
      && state_q == sar_pkg::ST_IDLE && power_en_q
      |=> busy_q) else $error("pin edge ignored");
   a_count_bound: assert property (
      @(posedge aclk) disable iff (!aresetn)
      cnt_q < nconv) else $error("count overrun");
endmodule

// [hdl/sar_pkg.sv]
package sar_pkg;
   // Register byte offsets; the index of a word is offset[4:2].
   localparam logic [7:0] OFS_CTRL   = 8'h00;
   localparam logic [7:0] OFS_CFG    = 8'h04;
   localparam logic [7:0] OFS_ACC    = 8'h08;
   localparam logic [7:0] OFS_TIME   = 8'h0C;
   localparam logic [7:0] OFS_RESULT = 8'h10;
   localparam logic [7:0] OFS_WIN_GT = 8'h14;
   localparam logic [7:0] OFS_WIN_LT = 8'h18;
   localparam logic [2:0] NREG       = 3'h7;
   // Control word fields.
   localparam int CTRL_PWR   = 0;
   localparam int CTRL_BURST = 1;
   localparam int CTRL_DONE  = 2;
   localparam int CTRL_BUSY  = 3;
   localparam int CTRL_LPTRK = 4;
   localparam int CTRL_SRC   = 5;
   localparam int CTRL_IRQEN = 8;
   localparam int CTRL_WIN   = 9;
   // Configuration, accumulator and timing fields.
   localparam int CFG_DIV    = 0;
   localparam int CFG_EIGHT  = 5;
   localparam int CFG_GAIN   = 6;
   localparam int ACC_RPT    = 0;
   localparam int ACC_JST    = 3;
   localparam int ACC_TWELVE = 7;
   localparam int TIME_PWR   = 0;
   localparam int TIME_TRK   = 8;
   // Values after reset.
   localparam logic [4:0] RST_DIV = 5'h01;
   localparam logic [4:0] RST_PWR = 5'h04;
   localparam logic [3:0] RST_TRK = 4'h1;
   // Start sources.
   localparam logic [2:0] SRC_BUSY = 3'h0;
   localparam logic [2:0] SRC_T0   = 3'h1;
   localparam logic [2:0] SRC_T2   = 3'h2;
   localparam logic [2:0] SRC_T3   = 3'h3;
   localparam logic [2:0] SRC_EXT  = 3'h4;
   // SAR clock counts, bit positions, initial code and bus responses.
   localparam logic [5:0] LP_TRACK_TICKS = 6'h03;
   localparam logic [3:0] CONV_EXTRA     = 4'h3;
   localparam logic [3:0] BITS_TEN       = 4'hA;
   localparam logic [3:0] BITS_EIGHT     = 4'h8;
   localparam logic [3:0] BIT_TOP        = 4'h9;
   localparam logic [9:0] SAR_INIT       = 10'h200;
   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_PWRUP = 2'b01,
      ST_TRACK = 2'b11,
      ST_CONV  = 2'b10
   } sar_state_e;

   typedef struct packed {
      logic t0_ovf;
      logic t2_lo_ovf;
      logic t2_hi_ovf;
      logic t2_16bit;
      logic t3_lo_ovf;
      logic t3_hi_ovf;
      logic t3_16bit;
   } sar_timer_s;

   typedef struct packed {
      logic       power_on;
      logic       track;
      logic       gain_half;
      logic [1:0] ref_step;
      logic [1:0] dem_sel;
   } sar_analog_s;
endpackage

// [testbench/sar_far_model.sv]
`timescale 1ns/100ps
// Comparator and burst oscillator seen from the converter's analog side.
module sar_far_model (
   input  wire logic       aclk,
   input  wire logic       aresetn,
   input  wire logic [9:0] dac_code,
   input  wire logic [9:0] vin,
   output logic            cmp_above,
   output logic            lpo_tick
);
   // A level compare keeps every trial bit whose code is at or below vin.
   assign cmp_above = (vin >= dac_code);
   // The oscillator runs at half the system rate so ticks never bunch up.
   always_ff @(posedge aclk) begin
      if (!aresetn) lpo_tick <= 1'b0;
      else lpo_tick <= ~lpo_tick;
   end
endmodule

// [testbench/tb.sv]
`timescale 1ns/100ps
module tb;
   logic aclk, aresetn, awvalid, wvalid, arvalid, pin, cmp, lpo;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata, rv;
   logic [1:0] bresp, rresp, bq;
   logic awready, wready, bvalid, arready, rvalid, irq;
   logic [9:0] dac, vin;
   sar_pkg::sar_timer_s tmr;
   sar_pkg::sar_analog_s ana;
   int mismatches, n_tests, cyc;
   sar_adc_seq dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
      .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hF),
      .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
      .bready(1'b1), .araddr(araddr), .arvalid(arvalid), .arready(arready),
      .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(1'b1),
      .timers(tmr), .ext_convert_start_pin(pin), .lpo_tick(lpo),
      .cmp_above(cmp), .dac_code(dac), .analog(ana), .conv_irq(irq));
   sar_far_model far (.aclk(aclk), .aresetn(aresetn), .dac_code(dac),
      .vin(vin), .cmp_above(cmp), .lpo_tick(lpo));
   initial begin
      aclk = 1'b0;
      forever #50 aclk = ~aclk;
   end
   task tally_and_finish;
      $display("comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // The run should need under a thousand cycles; this ceiling catches hangs.
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 30000) begin
         mismatches++;
         tally_and_finish;
      end
   end
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         mismatches++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      bq = bresp;
   endtask
   task rd(input logic [7:0] a);
      araddr <= a;
      arvalid <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      rv = rdata;
      bq = rresp;
   endtask
   task wait_done;
      int i;
      for (i = 0; i < 300 && rv[sar_pkg::CTRL_DONE] !== 1'b1; i++)
         rd(sar_pkg::OFS_CTRL);
   endtask
   task start_pulse(input logic ext, input logic [6:0] t);
      pin <= ext;
      tmr <= t;
      @(posedge aclk);
      tmr <= 7'h08;
      repeat (3) @(posedge aclk);
      pin <= 1'b0;
      repeat (40) @(posedge aclk);
   endtask
   task run_case(input logic [31:0] acc, input logic [31:0] ctl,
                 input logic [9:0] v);
      vin <= v;
      wr(sar_pkg::OFS_ACC, acc);
      // A start is taken only once power and burst already stand.
      wr(sar_pkg::OFS_CTRL, ctl & 32'hFFFF_FFF7);
      wr(sar_pkg::OFS_CTRL, ctl);
      rv = 32'h0000_0000;
   endtask
   initial begin
      {aresetn, awvalid, wvalid, arvalid, pin} = 5'h00;
      {awaddr, araddr, wdata} = '0;
      tmr = 7'h08;
      vin = 10'h155;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rd(sar_pkg::OFS_TIME);
      chk(rv, 32'h0000_0104);
      rd(8'h1C);
      chk({30'h0, bq}, {30'h0, sar_pkg::RESP_SLVERR});
      wr(8'h1C, 32'h0000_0001);
      chk({30'h0, bq}, {30'h0, sar_pkg::RESP_SLVERR});
      $display("test registers done");
      wr(sar_pkg::OFS_CFG, 32'h0000_0000);
      run_case(32'h0000_0000, 32'h0000_0009, 10'h155);
      wait_done;
      chk(rv[3:2], 2'b01);
      rd(sar_pkg::OFS_RESULT);
      chk(rv, 32'h0000_0155);
      chk({31'h0, irq}, 32'h0000_0000);
      chk({31'h0, ana.track}, 32'h0000_0001);
      wr(sar_pkg::OFS_CFG, 32'h0000_0060);
      run_case(32'h0000_0000, 32'h0000_0019, 10'h155);
      wait_done;
      rd(sar_pkg::OFS_RESULT);
      chk(rv, 32'h0000_5500);
      chk({31'h0, ana.gain_half}, 32'h0000_0001);
      chk({31'h0, ana.track}, 32'h0000_0000);
      wr(sar_pkg::OFS_CFG, 32'h0000_0000);
      $display("test single done");
      // Four pin starts without burst; done must wait for the fourth.
      run_case(32'h0000_0001, 32'h0000_0081, 10'h155);
      repeat (3) start_pulse(1'b1, 7'h08);
      start_pulse(1'b0, 7'h28);
      rd(sar_pkg::OFS_CTRL);
      chk(rv[2], 1'b0);
      chk(rv[9], 1'b0);
      start_pulse(1'b1, 7'h08);
      wait_done;
      chk(rv[9], 1'b1);
      rd(sar_pkg::OFS_RESULT);
      chk(rv, 32'h0000_0554);
      $display("test pin done");
      run_case(32'h0000_0001, 32'h0000_0042, 10'h0AB);
      start_pulse(1'b0, 7'h28);
      rd(sar_pkg::OFS_CTRL);
      chk(rv[3:2], 2'b00);
      start_pulse(1'b0, 7'h18);
      wait_done;
      rd(sar_pkg::OFS_RESULT);
      chk(rv, 32'h0000_02AC);
      run_case(32'h0000_0080, 32'h0000_010A, 10'h3FF);
      wait_done;
      rd(sar_pkg::OFS_RESULT);
      chk(rv, 32'h0000_0FFC);
      chk({31'h0, irq}, 32'h0000_0001);
      $display("test burst done");
      tally_and_finish;
   end
endmodule
